// [hw/ccr_cfg.svh]
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH
`define CCR_ADDR_MAIN      8'h01
`define CCR_ADDR_PATH      8'h02
`define CCR_ADDR_STAT      8'h03
`define CCR_ADDR_FAULT     8'h04
`define CCR_MAIN_RESET     8'h55
`define CCR_PATH_RESET     8'h16
`define CCR_BIT_SWRST      7
`define CCR_BIT_CHARGE_ENABLE     6
`define CCR_BIT_BOOST_EN   5
`define CCR_BIT_FACTORY    4
`define CCR_BIT_FOLDBACK   3
`define CCR_BIT_PORT_CFG   2
`define CCR_BIT_TMR_RST    1
`define CCR_BIT_INT_MASK   0
`define CCR_BIT_WDT_DIS    7
`define CCR_BIT_CTMR_DIS   6
`define CCR_BIT_PPATH      5
`define CCR_BIT_XCVR_EN    4
`define CCR_BIT_LIM_PIN    2
`define CCR_BIT_LIM_EN     1
`define CCR_BIT_AUTO_CC    0
`define CCR_STAT_MASK      8'h3D
`define CCR_FAULT_MASK     8'h1A
`define CCR_FLAG_PULSE_NS  128000
`endif

// [hw/ccr_pkg.sv]
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_PL_IDLE = 2'b00,
    CCR_PL_PULSE = 2'b01,
    CCR_PL_HOLD = 2'b11
  } ccr_pulse_st_t;
endpackage

// [hw/ccr_flag_if.sv]
`timescale 1ns/100ps
interface ccr_flag_if;
  logic [7:0] cond;
  logic [7:0] rise;
  logic [7:0] clr;
  logic [7:0] flags;
  modport owner (input cond, input rise, input clr, output flags);
  modport user  (output cond, output rise, output clr, input flags);
endinterface

// [hw/ccr_flag_reg.sv]
`timescale 1ns/100ps
module ccr_flag_reg #(
  parameter logic [7:0] MASK = 8'hFF
) (
  input  wire logic      i_sys_clk,
  input  wire logic      i_rst_n,
  input  wire logic      i_ce,
  ccr_flag_if.owner      fl
);
  typedef struct packed {
    logic [7:0] cond_q;
    logic [7:0] flags_q;
  } ccr_fr_state_t;
  ccr_fr_state_t s_q;
  ccr_fr_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.cond_q = fl.cond & MASK;
    // Set beats clear so a same-cycle event survives the read
    s_d.flags_q = ((s_q.flags_q & ~fl.clr)
                | (fl.cond & ~s_q.cond_q) | fl.rise) & MASK; // RULE21
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign fl.flags = s_q.flags_q;
endmodule

// [hw/ccr_regs.sv]
`timescale 1ns/100ps
`include "ccr_cfg.svh"
// Contract
// RULE1: Writing one to bit 7 of main control resets every register.
// RULE2: Charge enable resets one; clear halts charge or boost, set resumes.
// RULE3: Boost enable resets zero, clears on charge entry, set by host or pin.
// RULE4: Foldback bit, reset zero, reduces charge current when too hot.
// RULE5: Read-only port bit, reset one, picks limiter or full FET path.
// RULE6: Timer restart bit restarts charge timer, self clears, cleared by reset.
// RULE7: Global mask resets one; set blocks all interrupts.
// RULE8: Watchdog disable bit stops watchdog; cleared on boost entry.
// RULE9: Charge timer disable bit stops the timer; cleared on boost entry.
// RULE10: Power path bit enables dynamic path management; boost entry clears.
// RULE11: Transceiver supply bit, reset one, powers the transceiver pin.
// RULE12: Limit source bit picks pins or register values for limit and auto.
// RULE13: Limit enable bit applies the 4-bit limit code, else no limit.
// RULE14: Auto charge-current bit enables auto adjust; boost entry clears.
// RULE15: Status flags at bits 5..2 report four temperature thresholds.
// RULE16: Bit 0 of status reports bus in range; boost entry clears.
// RULE17: Fault flags detect, overvoltage lockout, battery overvoltage; boost clears.
// RULE18: Flags clear on host read and can raise a request unless masked.
// RULE19: Unmasked events give one flag pulse until the flags are cleared.
// RULE20: Host uses byte-wide addressed reads and writes as a bus target.
// RULE21: Flags set on the active transition and hold until read.
module ccr_regs #(
  parameter int unsigned CLK_MHZ    = 50,
  parameter int unsigned PULSE_CYC  = (`CCR_FLAG_PULSE_NS * CLK_MHZ) / 1000
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire logic       i_off_state,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_boost_pin,
  input  wire logic       i_boost_mode_entry,
  input  wire logic       i_charge_mode_entry,
  input  wire logic       i_timer_reset_event,
  input  wire logic       i_tj_too_high,
  input  wire logic [3:0] i_limit_select_pins,
  input  wire logic       i_limit_pins_auto,
  input  wire logic [3:0] i_input_limit_code,
  input  wire logic       i_auto_cc_reg,
  input  wire logic [3:0] i_temp_above,
  input  wire logic       i_bus_range_ok,
  input  wire logic       i_charger_detect,
  input  wire logic       i_input_overvoltage,
  input  wire logic       i_battery_overvoltage,
  output logic      [7:0] o_rdata,
  output logic            o_rvalid,
  output logic            o_charge_halt,
  output logic            o_boost_output_enable,
  output logic            o_factory_mode_select,
  output logic            o_current_foldback,
  output logic            o_reverse_block_fet_path,
  output logic            o_charge_timer_restart,
  output logic            o_watchdog_run,
  output logic            o_charge_timer_run,
  output logic            o_power_path_enable,
  output logic            o_transceiver_supply,
  output logic            o_limit_active,
  output logic      [3:0] o_limit_code,
  output logic            o_auto_charge_current_enable,
  output logic            o_status_flag_n
);
  // Pulse counter is 16 bits wide
  if (PULSE_CYC < 1 || PULSE_CYC > 65535) begin : g_bad_pulse
    $error("ccr_regs: PULSE_CYC out of range");
  end

  typedef struct packed {
    logic [7:0]                   main_q;
    logic [7:0]                   path_q;
    logic [7:0]                   rdata_q;
    logic                         rvalid_q;
    logic                         boost_pin_q;
    logic                         halt_q;
    logic                         boost_en_q;
    logic                         factory_q;
    logic                         foldback_q;
    logic                         rbfet_q;
    logic                         tmr_restart_q;
    logic                         wdt_run_q;
    logic                         ctmr_run_q;
    logic                         ppath_q;
    logic                         xcvr_q;
    logic                         lim_act_q;
    logic [3:0]                   lim_code_q;
    logic                         auto_q;
    ccr_pkg::ccr_pulse_st_t       pl_st_q;
    logic [15:0]                  pl_cnt_q;
    logic                         flag_n_q;
  } ccr_state_t;

  ccr_state_t s_q;
  ccr_state_t s_d;

  ccr_flag_if stat_fl ();
  ccr_flag_if fault_fl ();

  logic wr_main;
  logic wr_path;
  logic rd_stat;
  logic rd_fault;
  logic sw_rst;
  logic clr_all;

  // Byte-wide addressed target
  assign wr_main  = i_wr && (i_addr == `CCR_ADDR_MAIN); // RULE20
  assign wr_path  = i_wr && (i_addr == `CCR_ADDR_PATH); // RULE20
  assign rd_stat  = i_rd && (i_addr == `CCR_ADDR_STAT);
  assign rd_fault = i_rd && (i_addr == `CCR_ADDR_FAULT);
  assign sw_rst   = wr_main && i_wdata[`CCR_BIT_SWRST]; // RULE1
  assign clr_all  = sw_rst || i_off_state;

  // Comparator levels feed edge-set flags
  assign stat_fl.cond = clr_all ? 8'h00 :
                        {2'b00, i_temp_above, 1'b0, i_bus_range_ok}; // RULE15
  assign stat_fl.rise = 8'h00;
  assign stat_fl.clr  = clr_all ? 8'hFF :
                        ({8{rd_stat}}                                // RULE18
                       | {7'h00, i_boost_mode_entry}); // RULE16
  assign fault_fl.cond = clr_all ? 8'h00 :
                         {3'b000, i_charger_detect, i_input_overvoltage,
                          1'b0, i_battery_overvoltage, 1'b0}; // RULE17
  assign fault_fl.rise = 8'h00;
  assign fault_fl.clr  = (clr_all || i_boost_mode_entry || rd_fault)
                         ? 8'hFF : 8'h00; // RULE17

  ccr_flag_reg #(
    .MASK (`CCR_STAT_MASK)
  ) u_stat (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .fl        (stat_fl)
  );

  ccr_flag_reg #(
    .MASK (`CCR_FAULT_MASK)
  ) u_fault (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .fl        (fault_fl)
  );

  logic any_flag;
  assign any_flag = |{stat_fl.flags, fault_fl.flags};

  always_comb begin
    s_d = s_q;
    s_d.rvalid_q = i_rd;
    s_d.boost_pin_q = i_boost_pin;
    s_d.main_q[`CCR_BIT_TMR_RST] = 1'b0; // RULE6
    if (wr_main) begin
      s_d.main_q = i_wdata;
      s_d.main_q[`CCR_BIT_PORT_CFG] = s_q.main_q[`CCR_BIT_PORT_CFG]; // RULE5
    end
    if (wr_path) begin
      s_d.path_q = i_wdata;
      s_d.path_q[3] = 1'b0;
    end
    // Pin rising edge requests boost like a host write
    if (i_boost_pin && !s_q.boost_pin_q) begin
      s_d.main_q[`CCR_BIT_BOOST_EN] = 1'b1; // RULE3
    end
    if (i_charge_mode_entry) begin
      s_d.main_q[`CCR_BIT_BOOST_EN] = 1'b0; // RULE3
    end
    if (i_timer_reset_event) begin
      s_d.main_q[`CCR_BIT_TMR_RST] = 1'b0; // RULE6
    end
    if (i_boost_mode_entry) begin
      s_d.main_q[`CCR_BIT_FACTORY] = 1'b0;
      s_d.path_q[`CCR_BIT_WDT_DIS]  = 1'b0; // RULE8
      s_d.path_q[`CCR_BIT_CTMR_DIS] = 1'b0; // RULE9
      s_d.path_q[`CCR_BIT_PPATH]    = 1'b0; // RULE10
      s_d.path_q[`CCR_BIT_LIM_PIN]  = 1'b1;
      s_d.path_q[`CCR_BIT_LIM_EN]   = 1'b1;
      s_d.path_q[`CCR_BIT_AUTO_CC]  = 1'b0; // RULE14
    end
    if (clr_all) begin
      s_d.main_q = `CCR_MAIN_RESET; // RULE1
      s_d.path_q = `CCR_PATH_RESET; // RULE1
    end
    // Read data: flags sampled before their read clear
    case (i_addr)
      `CCR_ADDR_MAIN:  s_d.rdata_q = s_q.main_q;
      `CCR_ADDR_PATH:  s_d.rdata_q = s_q.path_q;
      `CCR_ADDR_STAT:  s_d.rdata_q = stat_fl.flags;
      `CCR_ADDR_FAULT: s_d.rdata_q = fault_fl.flags;
      default:         s_d.rdata_q = 8'h00;
    endcase
    if (!i_rd) begin
      s_d.rdata_q = s_q.rdata_q;
    end
    // Function outputs follow the next register image
    s_d.halt_q     = !s_d.main_q[`CCR_BIT_CHARGE_ENABLE]; // RULE2
    s_d.boost_en_q = s_d.main_q[`CCR_BIT_BOOST_EN] &&
                     s_d.main_q[`CCR_BIT_CHARGE_ENABLE]; // RULE2
    s_d.factory_q  = s_d.main_q[`CCR_BIT_FACTORY];
    s_d.foldback_q = s_d.main_q[`CCR_BIT_FOLDBACK] && i_tj_too_high; // RULE4
    s_d.rbfet_q    = s_d.main_q[`CCR_BIT_PORT_CFG]; // RULE5
    s_d.tmr_restart_q = wr_main && i_wdata[`CCR_BIT_TMR_RST]
                        && !clr_all; // RULE6
    s_d.wdt_run_q  = !s_d.path_q[`CCR_BIT_WDT_DIS]; // RULE8
    s_d.ctmr_run_q = !s_d.path_q[`CCR_BIT_CTMR_DIS]; // RULE9
    s_d.ppath_q    = s_d.path_q[`CCR_BIT_PPATH]; // RULE10
    s_d.xcvr_q     = s_d.path_q[`CCR_BIT_XCVR_EN]; // RULE11
    s_d.lim_act_q  = s_d.path_q[`CCR_BIT_LIM_EN]; // RULE13
    if (s_d.path_q[`CCR_BIT_LIM_PIN]) begin
      s_d.lim_code_q = i_limit_select_pins; // RULE12
      s_d.auto_q     = i_limit_pins_auto; // RULE12
    end else begin
      s_d.lim_code_q = i_input_limit_code; // RULE12
      s_d.auto_q     = s_d.path_q[`CCR_BIT_AUTO_CC] && i_auto_cc_reg; // RULE14
    end
    if (!s_d.path_q[`CCR_BIT_LIM_EN]) begin
      s_d.lim_code_q = 4'h0; // RULE13
    end
    // One pulse per batch of pending flags
    case (s_q.pl_st_q)
      ccr_pkg::CCR_PL_IDLE: begin
        if (any_flag && !s_q.main_q[`CCR_BIT_INT_MASK]) begin // RULE7
          s_d.pl_st_q  = ccr_pkg::CCR_PL_PULSE; // RULE19
          s_d.pl_cnt_q = 16'(PULSE_CYC - 1);
          s_d.flag_n_q = 1'b0;
        end
      end
      ccr_pkg::CCR_PL_PULSE: begin
        if (s_q.pl_cnt_q == 16'h0000) begin
          s_d.pl_st_q  = ccr_pkg::CCR_PL_HOLD;
          s_d.flag_n_q = 1'b1;
        end else begin
          s_d.pl_cnt_q = s_q.pl_cnt_q - 16'h0001;
        end
      end
      ccr_pkg::CCR_PL_HOLD: begin
        if (!any_flag) begin
          s_d.pl_st_q = ccr_pkg::CCR_PL_IDLE; // RULE19
        end
      end
      default: begin
        s_d.pl_st_q  = ccr_pkg::CCR_PL_IDLE;
        s_d.flag_n_q = 1'b1;
      end
    endcase
    if (s_q.main_q[`CCR_BIT_INT_MASK] || clr_all) begin
      s_d.flag_n_q = 1'b1; // RULE7
      if (s_q.pl_st_q == ccr_pkg::CCR_PL_PULSE) begin
        s_d.pl_st_q = ccr_pkg::CCR_PL_HOLD;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s_q          <= '0;
      s_q.main_q   <= `CCR_MAIN_RESET;
      s_q.path_q   <= `CCR_PATH_RESET;
      s_q.rbfet_q  <= 1'b1;
      s_q.wdt_run_q  <= 1'b1;
      s_q.ctmr_run_q <= 1'b1;
      s_q.factory_q  <= 1'b1;
      s_q.xcvr_q   <= 1'b1;
      s_q.lim_act_q <= 1'b1;
      s_q.flag_n_q <= 1'b1;
      s_q.pl_st_q  <= ccr_pkg::CCR_PL_IDLE;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_rdata                      = s_q.rdata_q;
  assign o_rvalid                     = s_q.rvalid_q;
  assign o_charge_halt                = s_q.halt_q;
  assign o_boost_output_enable        = s_q.boost_en_q;
  assign o_factory_mode_select        = s_q.factory_q;
  assign o_current_foldback           = s_q.foldback_q;
  assign o_reverse_block_fet_path     = s_q.rbfet_q;
  assign o_charge_timer_restart       = s_q.tmr_restart_q;
  assign o_watchdog_run               = s_q.wdt_run_q;
  assign o_charge_timer_run           = s_q.ctmr_run_q;
  assign o_power_path_enable          = s_q.ppath_q;
  assign o_transceiver_supply         = s_q.xcvr_q;
  assign o_limit_active               = s_q.lim_act_q;
  assign o_limit_code                 = s_q.lim_code_q;
  assign o_auto_charge_current_enable = s_q.auto_q;
  assign o_status_flag_n              = s_q.flag_n_q;
endmodule

// [bench/ccr_host.sv]
`timescale 1ns/100ps
module ccr_host (
  input  wire logic       i_sys_clk,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  initial {o_wr, o_rd, o_addr, o_wdata} = 18'h00000;
  // One byte per strobe; lines scrambled once released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_wr    <= w;
    o_rd    <= !w;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_sys_clk);
    o_wr    <= 1'b0;
    o_rd    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask
endmodule

// [bench/ccr_regs_sva.sv]
`timescale 1ns/100ps
module ccr_regs_sva #(
  parameter int unsigned PULSE_CYC = 4
) (
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  input wire logic       i_ce,
  input wire logic       i_off_state,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_boost_mode_entry,
  input wire logic       i_charge_mode_entry,
  input wire logic       i_tj_too_high,
  input wire logic       o_rvalid,
  input wire logic       o_charge_halt,
  input wire logic       o_boost_output_enable,
  input wire logic       o_current_foldback,
  input wire logic       o_charge_timer_restart,
  input wire logic       o_watchdog_run,
  input wire logic       o_limit_active,
  input wire logic [3:0] o_limit_code,
  input wire logic       o_status_flag_n
);
  logic [15:0] lo_q;
  wire         wr_main = i_wr && i_addr == 8'h01;
  wire         wr_path = i_wr && i_addr == 8'h02;
  // Low time of the flag pin; a cut pulse trips it
  always_ff @(posedge i_sys_clk) begin
    lo_q <= (!i_rst_n || o_status_flag_n) ? 16'h0000 : lo_q + 16'h0001;
  end
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n || i_off_state || !i_ce);
  property p_rvalid; i_rd |=> o_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("no read answer");
  property p_halt;
    wr_main && !i_wdata[7] |-> ##2 o_charge_halt != $past(i_wdata[6], 2);
  endproperty
  a_halt: assert property (p_halt) else $error("halt wrong");
  property p_boost; i_charge_mode_entry |-> ##2 !o_boost_output_enable;
  endproperty
  a_boost: assert property (p_boost) else $error("boost kept");
  property p_fold; !i_tj_too_high ##1 !i_tj_too_high |=> !o_current_foldback;
  endproperty
  a_fold: assert property (p_fold) else $error("foldback cool");
  property p_restart;
    wr_main && i_wdata[1] && !i_wdata[7]
      |-> ##[1:2] o_charge_timer_restart ##1 !o_charge_timer_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("restart pulse");
  property p_wdog;
    wr_path && i_wdata[7] && !i_boost_mode_entry |-> ##2 !o_watchdog_run;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog runs");
  property p_limit;
    wr_path && !i_wdata[1] |-> ##2 !o_limit_active && o_limit_code == 4'h0;
  endproperty
  a_limit: assert property (p_limit) else $error("limit applied");
  property p_plen; $rose(o_status_flag_n) |-> lo_q == PULSE_CYC; endproperty
  a_plen: assert property (p_plen) else $error("pulse short");
  property p_pmax; lo_q <= PULSE_CYC; endproperty
  a_pmax: assert property (p_pmax) else $error("pulse long");
endmodule
bind ccr_regs ccr_regs_sva #(.PULSE_CYC(PULSE_CYC)) u_sva (
  .i_sys_clk, .i_rst_n, .i_ce, .i_off_state, .i_wr, .i_rd, .i_addr,
  .i_wdata, .i_boost_mode_entry, .i_charge_mode_entry, .i_tj_too_high,
  .o_rvalid, .o_charge_halt, .o_boost_output_enable, .o_current_foldback,
  .o_charge_timer_restart, .o_watchdog_run, .o_limit_active, .o_limit_code,
  .o_status_flag_n
);

// [bench/charger_control_irq_registers_test.sv]
`timescale 1ns/100ps
module charger_control_irq_registers_test;
  logic        i_sys_clk, i_rst_n, i_ce, i_off_state, i_wr, i_rd;
  logic        i_boost_pin, i_boost_mode_entry, i_charge_mode_entry;
  logic        i_timer_reset_event, i_tj_too_high, i_limit_pins_auto;
  logic        i_auto_cc_reg, i_bus_range_ok, i_charger_detect;
  logic        i_input_overvoltage, i_battery_overvoltage, o_rvalid;
  logic [3:0]  i_limit_select_pins, i_input_limit_code, i_temp_above;
  logic [7:0]  i_addr, i_wdata, o_rdata;
  logic        o_charge_halt, o_boost_output_enable, o_current_foldback;
  logic        o_watchdog_run, o_charge_timer_run, o_power_path_enable;
  logic        o_transceiver_supply, o_limit_active, o_status_flag_n;
  logic [3:0]  o_limit_code;
  logic        o_factory_mode_select, o_reverse_block_fet_path;
  logic        o_charge_timer_restart, o_auto_charge_current_enable;
  logic [7:0]  exp_q[$];
  logic [7:0]  rv[5] = '{8'h55, 8'h16, 8'h00, 8'h00, 8'h00};
  logic [15:0] lf;
  int          compares, miscompares;
  ccr_regs #(.PULSE_CYC(4)) dut (
    .i_sys_clk, .i_rst_n, .i_ce, .i_off_state, .i_wr, .i_rd, .i_addr,
    .i_wdata, .i_boost_pin, .i_boost_mode_entry, .i_charge_mode_entry,
    .i_timer_reset_event, .i_tj_too_high, .i_limit_select_pins,
    .i_limit_pins_auto, .i_input_limit_code, .i_auto_cc_reg, .i_temp_above,
    .i_bus_range_ok, .i_charger_detect, .i_input_overvoltage,
    .i_battery_overvoltage, .o_rdata, .o_rvalid, .o_charge_halt,
    .o_boost_output_enable, .o_factory_mode_select, .o_current_foldback,
    .o_reverse_block_fet_path, .o_charge_timer_restart, .o_watchdog_run,
    .o_charge_timer_run, .o_power_path_enable, .o_transceiver_supply,
    .o_limit_active, .o_limit_code, .o_auto_charge_current_enable,
    .o_status_flag_n
  );
  ccr_host h (.i_sys_clk, .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr),
    .o_wdata(i_wdata));
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    h.xfer(1'b0, a, 8'h00);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic wlow;
    for (int n = 0; n < 40; n++) begin
      @(posedge i_sys_clk);
      if (o_status_flag_n === 1'b0) return;
    end
    miscompares++;
    end_sim;
  endtask
  always @(posedge i_sys_clk) begin
    if (o_rvalid === 1'b1) cmp(o_rdata, exp_q.pop_front());
  end
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #1000000;
    miscompares++;
    end_sim;
  end
  initial begin
    {i_rst_n, i_off_state, i_boost_pin, i_boost_mode_entry} = 4'h0;
    {i_charge_mode_entry, i_timer_reset_event, i_tj_too_high} = 3'h0;
    {i_limit_pins_auto, i_auto_cc_reg, i_bus_range_ok} = 3'h0;
    {i_charger_detect, i_input_overvoltage, i_battery_overvoltage} = 3'h0;
    {i_limit_select_pins, i_input_limit_code, i_temp_above} = 12'h000;
    i_ce = 1'b1;
    lf = 16'h8C71;
    wt(10);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 5; k++) rd(8'(k + 1), rv[k]);
    // First pass forces limit off, the rest are random
    for (int k = 0; k < 5; k++) begin
      lf = (k == 0) ? {lf[15:8], 8'hC0} : nx(lf);
      {i_input_limit_code, i_limit_select_pins} <= lf[15:8];
      {i_limit_pins_auto, i_auto_cc_reg} <= lf[9:8];
      h.xfer(1'b1, 8'h02, lf[7:0]);
      wt(2);
      cmp({o_watchdog_run, o_charge_timer_run, o_power_path_enable,
        o_transceiver_supply, o_limit_active, o_limit_code}, {~lf[7:6],
        lf[5:4], lf[1], lf[1] ? (lf[2] ? lf[11:8] : lf[15:12]) : 4'h0});
      cmp(o_auto_charge_current_enable, lf[2] ? lf[9] : lf[0] & lf[8]);
      rd(8'h02, lf[7:0] & 8'hF7);
    end
    i_tj_too_high <= 1'b1;
    h.xfer(1'b1, 8'h01, 8'h4A);
    wt(1);
    cmp(o_charge_timer_restart, 1'b1);
    wt(1);
    cmp(o_current_foldback, 1'b1);
    cmp(o_charge_timer_restart, 1'b0);
    cmp({o_factory_mode_select, o_reverse_block_fet_path}, 2'b01);
    rd(8'h01, 8'h4C);
    i_tj_too_high <= 1'b0;
    i_temp_above <= 4'hF;
    i_bus_range_ok <= 1'b1;
    wlow;
    rd(8'h03, 8'h3D);
    rd(8'h03, 8'h00);
    {i_charger_detect, i_input_overvoltage, i_battery_overvoltage} <= 3'h7;
    wt(3);
    rd(8'h04, 8'h1A);
    {i_bus_range_ok, i_charger_detect, i_input_overvoltage} <= 3'h0;
    i_battery_overvoltage <= 1'b0;
    wt(2);
    {i_bus_range_ok, i_charger_detect, i_input_overvoltage} <= 3'h7;
    i_battery_overvoltage <= 1'b1;
    wt(3);
    i_boost_mode_entry <= 1'b1;
    wt(1);
    i_boost_mode_entry <= 1'b0;
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    i_temp_above <= 4'h0;
    wt(10);
    h.xfer(1'b1, 8'h01, 8'h55);
    i_temp_above <= 4'hF;
    for (int k = 0; k < 12; k++) begin
      wt(1);
      cmp(o_status_flag_n, 1'b1);
    end
    i_boost_pin <= 1'b1;
    wt(3);
    cmp(o_boost_output_enable, 1'b1);
    i_charge_mode_entry <= 1'b1;
    wt(1);
    i_charge_mode_entry <= 1'b0;
    wt(2);
    cmp(o_boost_output_enable, 1'b0);
    h.xfer(1'b1, 8'h01, 8'h14);
    wt(2);
    cmp(o_charge_halt, 1'b1);
    rd(8'h01, 8'h14);
    // Quiet status comparators so no fresh status edge follows the reset
    {i_temp_above, i_bus_range_ok} <= 5'h00;
    wt(8);
    h.xfer(1'b1, 8'h01, 8'h80);
    for (int k = 0; k < 3; k++) rd(8'(k + 1), rv[k]);
    wt(4);
    if (exp_q.size() != 0) miscompares++;
    end_sim;
  end
endmodule
